/* File: hdl/aifv_pkg.sv */
package aifv_pkg;

  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int NUM_SLOTS = 16;
  localparam int REG_W = 16;
  localparam int NUM_OVF = 2;
  localparam int STRB_W = AXI_DW / 8;

  // Register byte addresses
  localparam logic [AXI_AW-1:0] OFS_ENABLE = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_FLAGS = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_VECTOR = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_OVF_STAT = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_OVF_MASK = 8'h10;

  // Reset values
  localparam logic [REG_W-1:0] RST_ENABLE = 16'h0000;
  localparam logic [REG_W-1:0] RST_FLAGS = 16'h0000;
  localparam logic [NUM_OVF-1:0] RST_OVF = 2'h0;

  // Overflow status bit positions
  localparam int OVF_RESULT_BIT = 0;
  localparam int OVF_TIME_BIT = 1;

  // Vector code field, bits 5 to 1
  localparam int CODE_LSB = 1;
  localparam int CODE_W = 5;
  localparam int CODE_MSB = CODE_LSB + CODE_W - 1;
  localparam logic [CODE_W-1:0] CODE_NONE = 5'h00;
  localparam logic [CODE_W-1:0] CODE_RES_OVF = 5'h01;
  localparam logic [CODE_W-1:0] CODE_TIME_OVF = 5'h02;
  localparam logic [CODE_W-1:0] CODE_FLAG0 = 5'h03;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_ENABLE,
    SEL_FLAGS,
    SEL_VECTOR,
    SEL_OVF_STAT,
    SEL_OVF_MASK,
    SEL_NONE
  } aifv_sel_t;

  function automatic aifv_sel_t aifv_decode(
    input logic [AXI_AW-1:0] addr
  );
    case (addr)
      OFS_ENABLE: return SEL_ENABLE;
      OFS_FLAGS: return SEL_FLAGS;
      OFS_VECTOR: return SEL_VECTOR;
      OFS_OVF_STAT: return SEL_OVF_STAT;
      OFS_OVF_MASK: return SEL_OVF_MASK;
      default: return SEL_NONE;
    endcase
  endfunction : aifv_decode

  // Byte-lane merge for a 16-bit register in the low half-word
  function automatic logic [REG_W-1:0] aifv_merge16(
    input logic [REG_W-1:0] old,
    input logic [AXI_DW-1:0] data,
    input logic [STRB_W-1:0] strb
  );
    logic [REG_W-1:0] res;
    res = old;
    if (strb[0])
    begin
      res[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : aifv_merge16

endpackage : aifv_pkg

/* File: hdl/aifv_top.sv */
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module aifv_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [aifv_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [aifv_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [aifv_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [aifv_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [aifv_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [aifv_pkg::NUM_SLOTS-1:0] slot_load,
  input wire logic [aifv_pkg::NUM_SLOTS-1:0] slot_access,
  input wire logic result_ovf_evt,
  input wire logic time_ovf_evt,
  output logic irq
);

  logic awready_ff;
  logic aw_hold_ff;
  logic [aifv_pkg::AXI_AW-1:0] awaddr_ff;
  logic wready_ff;
  logic w_hold_ff;
  logic [aifv_pkg::AXI_DW-1:0] wdata_ff;
  logic [aifv_pkg::STRB_W-1:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [aifv_pkg::AXI_DW-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  aifv_pkg::aifv_sel_t rd_sel_ff;

  logic [aifv_pkg::REG_W-1:0] result_irq_enable_mask_ff;
  logic [aifv_pkg::REG_W-1:0] result_irq_flags_ff;
  logic [aifv_pkg::CODE_W-1:0] irq_vector_code_ff;
  logic [aifv_pkg::NUM_OVF-1:0] ovf_status_ff;
  logic [aifv_pkg::NUM_OVF-1:0] ovf_mask_ff;
  logic irq_ff;

  logic [aifv_pkg::REG_W-1:0] nxt_flags;
  logic [aifv_pkg::NUM_OVF-1:0] nxt_ovf;
  logic [aifv_pkg::NUM_OVF-1:0] ovf_evt;
  logic [aifv_pkg::NUM_OVF-1:0] ovf_w1c;
  logic [aifv_pkg::AXI_DW-1:0] rd_word;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_do;
  aifv_pkg::aifv_sel_t wr_sel;
  aifv_pkg::aifv_sel_t ar_sel;

  aifv_vec_if vif ();

  aifv_vec_enc u_enc (
    .vif(vif.enc)
  );

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign irq = irq_ff;

  assign aw_hs = s_axi_awvalid & awready_ff;
  assign w_hs = s_axi_wvalid & wready_ff;
  assign ar_hs = s_axi_arvalid & arready_ff;
  // Address and data may arrive in either order; act once both are held
  assign wr_do = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign wr_sel = aifv_pkg::aifv_decode(awaddr_ff);
  assign ar_sel = aifv_pkg::aifv_decode(s_axi_araddr);

  // Write address channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b0;
      aw_hold_ff <= 1'b0;
      awaddr_ff <= '0;
    end
    else if (aw_hs)
    begin
      awready_ff <= 1'b0;
      aw_hold_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end
    else if (bvalid_ff && s_axi_bready)
    begin
      awready_ff <= 1'b1;
      aw_hold_ff <= 1'b0;
    end
    else if (!aw_hold_ff)
    begin
      awready_ff <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end
    else if (w_hs)
    begin
      wready_ff <= 1'b0;
      w_hold_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
    else if (bvalid_ff && s_axi_bready)
    begin
      wready_ff <= 1'b1;
      w_hold_ff <= 1'b0;
    end
    else if (!w_hold_ff)
    begin
      wready_ff <= 1'b1;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= aifv_pkg::RESP_OKAY;
    end
    else if (wr_do)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_sel == aifv_pkg::SEL_NONE) ?
        aifv_pkg::RESP_SLVERR : aifv_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read mux; vector code sits above a zero bit 0
  always_comb
  begin
    rd_word = '0;
    case (ar_sel)
      aifv_pkg::SEL_ENABLE:
        rd_word[aifv_pkg::REG_W-1:0] = result_irq_enable_mask_ff;
      aifv_pkg::SEL_FLAGS:
        rd_word[aifv_pkg::REG_W-1:0] = result_irq_flags_ff;
      aifv_pkg::SEL_VECTOR:
        rd_word[aifv_pkg::CODE_MSB:aifv_pkg::CODE_LSB] =
          irq_vector_code_ff;
      aifv_pkg::SEL_OVF_STAT:
        rd_word[aifv_pkg::NUM_OVF-1:0] = ovf_status_ff;
      aifv_pkg::SEL_OVF_MASK:
        rd_word[aifv_pkg::NUM_OVF-1:0] = ovf_mask_ff;
      default:
        rd_word = '0;
    endcase
  end

  // Read channel; answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= aifv_pkg::RESP_OKAY;
      rd_sel_ff <= aifv_pkg::SEL_NONE;
    end
    else if (ar_hs)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rd_sel_ff <= ar_sel;
      rresp_ff <= (ar_sel == aifv_pkg::SEL_NONE) ?
        aifv_pkg::RESP_SLVERR : aifv_pkg::RESP_OKAY;
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
    else if (!rvalid_ff)
    begin
      arready_ff <= 1'b1;
    end
  end

  // Enable mask
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_irq_enable_mask_ff <= aifv_pkg::RST_ENABLE;
    end
    else if (wr_do && wr_sel == aifv_pkg::SEL_ENABLE)
    begin
      result_irq_enable_mask_ff <= aifv_pkg::aifv_merge16(
        result_irq_enable_mask_ff, wdata_ff, wstrb_ff);
    end
  end

  // Hardware load wins over any clear in the same cycle
  always_comb
  begin
    nxt_flags = result_irq_flags_ff;
    if (wr_do && wr_sel == aifv_pkg::SEL_FLAGS)
    begin
      nxt_flags = aifv_pkg::aifv_merge16(
        result_irq_flags_ff, wdata_ff, wstrb_ff);
    end
    nxt_flags = nxt_flags & ~slot_access;
    nxt_flags = nxt_flags | slot_load;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_irq_flags_ff <= aifv_pkg::RST_FLAGS;
    end
    else
    begin
      result_irq_flags_ff <= nxt_flags;
    end
  end

  // Overflow status: sticky, write one to clear, event wins
  always_comb
  begin
    ovf_evt = '0;
    ovf_evt[aifv_pkg::OVF_RESULT_BIT] = result_ovf_evt;
    ovf_evt[aifv_pkg::OVF_TIME_BIT] = time_ovf_evt;
    ovf_w1c = '0;
    if (wr_do && wr_sel == aifv_pkg::SEL_OVF_STAT && wstrb_ff[0])
    begin
      ovf_w1c = wdata_ff[aifv_pkg::NUM_OVF-1:0];
    end
    nxt_ovf = (ovf_status_ff & ~ovf_w1c) | ovf_evt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovf_status_ff <= aifv_pkg::RST_OVF;
    end
    else
    begin
      ovf_status_ff <= nxt_ovf;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovf_mask_ff <= aifv_pkg::RST_OVF;
    end
    else if (wr_do && wr_sel == aifv_pkg::SEL_OVF_MASK && wstrb_ff[0])
    begin
      ovf_mask_ff <= wdata_ff[aifv_pkg::NUM_OVF-1:0];
    end
  end

  // Only enabled sources compete for the vector
  assign vif.pend_flags = result_irq_flags_ff & result_irq_enable_mask_ff;
  assign vif.pend_ovf = ovf_status_ff & ovf_mask_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_vector_code_ff <= aifv_pkg::CODE_NONE;
    end
    else
    begin
      irq_vector_code_ff <= vif.code;
    end
  end

  // Level request, one cycle behind the pending state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= (|vif.pend_flags) | (|vif.pend_ovf);
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_any_pend;
    (|vif.pend_flags) || (|vif.pend_ovf);
  endsequence

  sequence s_none_pend;
    (vif.pend_flags == '0) && (vif.pend_ovf == '0);
  endsequence

  chk_mask_write: assert property (
    (wr_do && wr_sel == aifv_pkg::SEL_ENABLE && wstrb_ff[1:0] == 2'h3)
    |=> result_irq_enable_mask_ff == $past(wdata_ff[15:0]))
    else $error("enable mask did not take written value");

  chk_flag_load: assert property (
    (slot_load != '0)
    |=> (result_irq_flags_ff & $past(slot_load)) == $past(slot_load))
    else $error("loaded slot flag not set");

  chk_flag_access: assert property (
    ((slot_access & ~slot_load) != '0
      && !(wr_do && wr_sel == aifv_pkg::SEL_FLAGS))
    |=> (result_irq_flags_ff & $past(slot_access & ~slot_load)) == '0)
    else $error("accessed slot flag not cleared");

  chk_vec_top: assert property (
    vif.pend_ovf[aifv_pkg::OVF_RESULT_BIT]
    |=> irq_vector_code_ff == aifv_pkg::CODE_RES_OVF)
    else $error("result overflow not top priority");

  chk_vec_flag0: assert property (
    (vif.pend_ovf == '0 && vif.pend_flags[0])
    |=> irq_vector_code_ff == aifv_pkg::CODE_FLAG0)
    else $error("flag 0 code wrong");

  chk_vec_read: assert property (
    (rvalid_ff && rd_sel_ff == aifv_pkg::SEL_VECTOR)
    |-> rdata_ff[0] == 1'b0 && rdata_ff[31:6] == '0)
    else $error("vector reserved bits not zero");

  chk_flags_reset: assert property (
    $rose(aresetn) |-> result_irq_flags_ff == '0
      && result_irq_enable_mask_ff == '0)
    else $error("flags or mask not zero after reset");

  chk_irq_raise: assert property (
    s_any_pend |=> irq_ff)
    else $error("request missing while enabled source pending");

  chk_irq_drop: assert property (
    s_none_pend ##1 s_none_pend |-> !irq_ff)
    else $error("request high with nothing pending");

endmodule : aifv_top

/* File: hdl/aifv_vec_enc.sv */
`timescale 1ns/1ps
module aifv_vec_enc (
  aifv_vec_if.enc vif
);

  // Walk from lowest priority upward so the last hit wins
  always_comb
  begin
    vif.code = aifv_pkg::CODE_NONE;
    for (int i = aifv_pkg::NUM_SLOTS - 1; i >= 0; i--)
    begin
      if (vif.pend_flags[i])
      begin
        vif.code = aifv_pkg::CODE_FLAG0
          + aifv_pkg::CODE_W'(i);
      end
    end
    if (vif.pend_ovf[aifv_pkg::OVF_TIME_BIT])
    begin
      vif.code = aifv_pkg::CODE_TIME_OVF;
    end
    if (vif.pend_ovf[aifv_pkg::OVF_RESULT_BIT])
    begin
      vif.code = aifv_pkg::CODE_RES_OVF;
    end
  end

endmodule : aifv_vec_enc

/* File: hdl/aifv_vec_if.sv */
`timescale 1ns/1ps
interface aifv_vec_if;
  logic [aifv_pkg::NUM_SLOTS-1:0] pend_flags;
  logic [aifv_pkg::NUM_OVF-1:0] pend_ovf;
  logic [aifv_pkg::CODE_W-1:0] code;

  modport enc (
    input pend_flags,
    input pend_ovf,
    output code
  );

  modport src (
    output pend_flags,
    output pend_ovf,
    input code
  );
endinterface : aifv_vec_if

/* File: test/aifv_evt_model.sv */
`timescale 1ns/1ps
module aifv_evt_model (
  input wire logic aclk,
  output logic [aifv_pkg::NUM_SLOTS-1:0] slot_load,
  output logic [aifv_pkg::NUM_SLOTS-1:0] slot_access,
  output logic result_ovf_evt,
  output logic time_ovf_evt
);
  initial
  begin
    slot_load = 16'h0000;
    slot_access = 16'h0000;
    result_ovf_evt = 1'b0;
    time_ovf_evt = 1'b0;
  end

  // One-cycle pulse, then idle long enough for irq to settle
  task automatic pulse(input int k, input int n);
    @(posedge aclk);
    case (k)
      0: slot_load <= 16'h0001 << n;
      1: slot_access <= 16'h0001 << n;
      2: result_ovf_evt <= 1'b1;
      default: time_ovf_evt <= 1'b1;
    endcase
    @(posedge aclk);
    slot_load <= 16'h0000;
    slot_access <= 16'h0000;
    result_ovf_evt <= 1'b0;
    time_ovf_evt <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : pulse
endmodule : aifv_evt_model

/* File: test/aifv_top_tb.sv */
`timescale 1ns/1ps
module aifv_top_tb;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic [15:0] ld;
  logic [15:0] acc;
  logic rovf;
  logic tovf;
  logic irq;
  logic [31:0] dv;
  logic [1:0] rs;
  int mismatches;
  int n_compared;

  aifv_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .slot_load(ld), .slot_access(acc),
    .result_ovf_evt(rovf), .time_ovf_evt(tovf), .irq(irq));

  aifv_evt_model evt (.aclk(aclk), .slot_load(ld), .slot_access(acc),
    .result_ovf_evt(rovf), .time_ovf_evt(tovf));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Bounded wait; a hang ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad;
    bit dd;
    int i;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 64; i++)
    begin
      @(posedge aclk);
      if (!ad && awready === 1'b1)
      begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!dd && wready === 1'b1)
      begin
        dd = 1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (i == 64)
    begin
      mismatches++;
      end_sim();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 64; i++)
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        dv = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (i == 64)
    begin
      mismatches++;
      end_sim();
    end
  endtask : rd

  task automatic cr(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("register", dv, e);
  endtask : cr

  initial
  begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    mismatches = 0;
    n_compared = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cr(aifv_pkg::OFS_ENABLE, 32'h0);
    cr(aifv_pkg::OFS_FLAGS, 32'h0);
    cr(aifv_pkg::OFS_VECTOR, 32'h0);
    rd(8'h14);
    chk("rresp", {30'h0, rs}, 32'h2);
    $display("test reset done");
    wr(aifv_pkg::OFS_ENABLE, 32'hffffa5a5);
    cr(aifv_pkg::OFS_ENABLE, 32'h0000a5a5);
    wr(aifv_pkg::OFS_ENABLE, 32'h0000ffff);
    for (int n = 0; n < 16; n++)
    begin
      evt.pulse(0, n);
      chk("irq", {31'h0, irq}, 32'h1);
      cr(aifv_pkg::OFS_FLAGS, 32'h1 << n);
      cr(aifv_pkg::OFS_VECTOR, 32'(6 + 2 * n));
      evt.pulse(1, n);
      cr(aifv_pkg::OFS_FLAGS, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
    end
    $display("test slots done");
    evt.pulse(0, 15);
    evt.pulse(0, 2);
    cr(aifv_pkg::OFS_VECTOR, 32'h0a);
    wr(aifv_pkg::OFS_OVF_MASK, 32'h3);
    evt.pulse(3, 0);
    cr(aifv_pkg::OFS_VECTOR, 32'h04);
    evt.pulse(2, 0);
    cr(aifv_pkg::OFS_VECTOR, 32'h02);
    cr(aifv_pkg::OFS_OVF_STAT, 32'h3);
    cr(aifv_pkg::OFS_OVF_MASK, 32'h3);
    wr(aifv_pkg::OFS_OVF_STAT, 32'h1);
    cr(aifv_pkg::OFS_VECTOR, 32'h04);
    wr(aifv_pkg::OFS_OVF_STAT, 32'h2);
    wr(aifv_pkg::OFS_VECTOR, 32'h3e);
    cr(aifv_pkg::OFS_VECTOR, 32'h0a);
    wr(aifv_pkg::OFS_FLAGS, 32'h0);
    cr(aifv_pkg::OFS_VECTOR, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    evt.pulse(3, 0);
    chk("irq", {31'h0, irq}, 32'h1);
    cr(aifv_pkg::OFS_VECTOR, 32'h04);
    wr(aifv_pkg::OFS_OVF_STAT, 32'h2);
    cr(aifv_pkg::OFS_OVF_STAT, 32'h0);
    $display("test priority done");
    // Upper lane only; lower half of the mask must survive
    wstrb <= 4'h2;
    wr(aifv_pkg::OFS_ENABLE, 32'h00000000);
    cr(aifv_pkg::OFS_ENABLE, 32'h000000ff);
    wstrb <= 4'hf;
    wr(aifv_pkg::OFS_ENABLE, 32'h0);
    evt.pulse(0, 5);
    chk("irq", {31'h0, irq}, 32'h0);
    cr(aifv_pkg::OFS_FLAGS, 32'h20);
    wr(aifv_pkg::OFS_FLAGS, 32'h3);
    cr(aifv_pkg::OFS_FLAGS, 32'h3);
    wr(aifv_pkg::OFS_ENABLE, 32'h1);
    repeat (3) @(posedge aclk);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h40, 32'h1);
    chk("bresp", {30'h0, rs}, 32'h2);
    $display("test mask done");
    end_sim();
  end
endmodule : aifv_top_tb
